// File: asd_pkg.sv
// Purpose: Shared constants and types of the address space decoder.
// Assumes: 32-bit CPU addresses, 29-bit external space.
// Notes:   Register offsets are byte addresses on the plain port.
`default_nettype none

package asd_pkg;

	// Widths
	localparam int ASD_ADDR_W = 32;
	localparam int ASD_EXT_W  = 29;
	localparam int ASD_TAG_W  = 8;
	localparam int ASD_REG_AW = 8;

	// Register offsets
	localparam logic [7:0] ASD_OFS_XLAT  = 8'h00;
	localparam logic [7:0] ASD_OFS_CACHE = 8'h04;
	localparam logic [7:0] ASD_OFS_PTAG  = 8'h08;
	localparam logic [7:0] ASD_OFS_FAULT = 8'h0c;

	// Translation control field positions
	localparam int ASD_XL_AT   = 0;
	localparam int ASD_XL_SQLK = 1;
	localparam int ASD_XL_SV   = 2;
	// Cache control field positions
	localparam int ASD_CC_CE  = 0;
	localparam int ASD_CC_WT  = 1;
	localparam int ASD_CC_CB  = 2;
	localparam int ASD_CC_ORA = 3;

	// Reset values
	localparam logic [2:0]  ASD_XLAT_RST  = 3'h0;
	localparam logic [3:0]  ASD_CACHE_RST = 4'h0;
	localparam logic [7:0]  ASD_PTAG_RST  = 8'h00;
	localparam logic [31:0] ASD_FAULT_RST = 32'h0000_0000;

	// Address tags
	localparam logic [5:0] ASD_SQ_TAG    = 6'h38; // e0..e3
	localparam logic [4:0] ASD_ARR_TAG   = 5'h1e; // f0..f7
	localparam logic [7:0] ASD_CREG_TAG  = 8'hff; // ff
	localparam logic [5:0] ASD_ORAM_TAG  = 6'h1f; // 7c..7f
	localparam logic [4:0] ASD_TCREG_TAG = 5'h1f; // ext 1f
	localparam logic [2:0] ASD_AREA_RSVD = 3'h7;

	// Region of a CPU address
	typedef enum logic [4:0] {
		ASD_RG_LOW  = 5'b00001,
		ASD_RG_CDIR = 5'b00010,
		ASD_RG_UDIR = 5'b00100,
		ASD_RG_HIGH = 5'b01000,
		ASD_RG_CTRL = 5'b10000
	} asd_region_t;

	// Where a decoded access goes
	typedef enum logic [5:0] {
		ASD_TG_EXT  = 6'b000001,
		ASD_TG_SQ   = 6'b000010,
		ASD_TG_ARR  = 6'b000100,
		ASD_TG_CREG = 6'b001000,
		ASD_TG_ORAM = 6'b010000,
		ASD_TG_RSVD = 6'b100000
	} asd_target_t;

endpackage : asd_pkg

`default_nettype wire

// File: asd_region_classify.sv
// Purpose: Sort a CPU address into its region and sub-windows.
// Assumes: Pure decode, no state.
// Notes:   Area field is taken from the untranslated address.
`default_nettype none

module asd_region_classify (
	// Address in
	input  wire logic [31:0]        addr,
	// Decode out
	output asd_pkg::asd_region_t    region,
	output logic                    is_sq,
	output logic                    is_arr,
	output logic                    is_creg,
	output logic                    is_p4rsvd,
	output logic                    is_oram,
	output logic [2:0]              area
);
	import asd_pkg::*;

	// Region by top three bits
	assign region = (addr[31] == 1'b0)    ? ASD_RG_LOW  :
	                (addr[30:29] == 2'h0) ? ASD_RG_CDIR :
	                (addr[30:29] == 2'h1) ? ASD_RG_UDIR :
	                (addr[30:29] == 2'h2) ? ASD_RG_HIGH :
	                                        ASD_RG_CTRL;

	// Control region windows
	assign is_sq     = (addr[31:26] == ASD_SQ_TAG);
	assign is_arr    = (addr[31:27] == ASD_ARR_TAG);
	assign is_creg   = (addr[31:24] == ASD_CREG_TAG);
	assign is_p4rsvd = (region == ASD_RG_CTRL) & ~is_sq & ~is_arr
	                   & ~is_creg;

	// On-chip RAM window candidate
	assign is_oram = (addr[31:26] == ASD_ORAM_TAG);

	// External area after folding
	assign area = addr[28:26];

endmodule : asd_region_classify

`default_nettype wire

// File: asd_decoder.sv
// Purpose: Address space decoder between CPU access paths and memory.
// Assumes: TLB answers combinationally in the request cycle.
// Notes:   One request per cycle, result registered one cycle later.
//
// Behaviour
// - Untranslated addresses drop their top three bits onto external space.
// - Privileged reaches all 4 Gbytes; user only the lower 2 Gbytes and the store queue.
// - User access to upper regions except store queue gives address error.
// - Untranslated cached regions follow cache enable; write mode from selects.
// - Uncached-direct region never caches; top three bits forced to zero.
// - Direct-mapped addresses landing in area 7 are reserved.
// - e0000000..e3ffffff is store queue; user lock applies untranslated.
// - Eight 16-Mbyte array windows f0..f7, always uncached, in order.
// - ff000000 upward is control registers; e4..ef and f8..fe reserved.
// - External space is eight 64-Mbyte areas; area 7 reserved.
// - With translation on, low, high and store queue addresses map via TLB.
// - Translated regions and store queue carry the 8-bit process tag.
// - Translated access to external 1f.. reaches control registers.
// - Translated caching needs cache enable and page cacheable; page write mode.
// - Direct and control regions are never translated, except store queue.
// - With RAM select set, 7c..7f is on-chip RAM, untranslated, data only.
// - Fetches use the instruction TLB; data uses the unified TLB.
// - TLB hit gives physical address; miss raises TLB miss exception.
// - Single-virtual select picks TLB compare mode only.
// - Changing the process tag switches process without a purge.
// - With translation off no MMU exception is raised.
// - With translation off, user lock set makes user store queue access an address error.
`default_nettype none

module asd_decoder (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	// Register port
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata,
	// CPU access request
	input  wire logic                    req_valid,
	input  wire logic [31:0]             req_addr,
	input  wire logic                    req_priv,
	input  wire logic                    req_fetch,
	// TLB lookup
	output logic                         tlb_lookup,
	output logic                         tlb_use_instruction_translation_buffer,
	output logic [7:0]                   tlb_tag,
	output logic                         tlb_single_virtual,
	input  wire logic                    tlb_hit,
	input  wire logic [28:0]             tlb_paddr,
	input  wire logic                    tlb_cacheable,
	input  wire logic                    tlb_write_through,
	// Decoded result
	output logic                         rsp_valid,
	output logic                         rsp_addr_error,
	output logic                         rsp_tlb_miss,
	output asd_pkg::asd_target_t         rsp_target,
	output logic [28:0]                  rsp_phys_addr,
	output logic [2:0]                   rsp_area,
	output logic [2:0]                   rsp_array_sel,
	output logic                         rsp_cacheable,
	output logic                         rsp_write_through,
	output logic                         rsp_translated
);
	import asd_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Control registers

	logic [2:0]  xlat_q;
	logic [3:0]  cache_q;
	logic [7:0]  ptag_q;
	logic [31:0] fault_q;
	logic [31:0] rdata_q;

	wire sel_xlat  = (reg_addr == ASD_OFS_XLAT);
	wire sel_cache = (reg_addr == ASD_OFS_CACHE);
	wire sel_ptag  = (reg_addr == ASD_OFS_PTAG);
	wire sel_fault = (reg_addr == ASD_OFS_FAULT);

	wire at_q   = xlat_q[ASD_XL_AT];
	wire sqlk_q = xlat_q[ASD_XL_SQLK];
	wire ce_q   = cache_q[ASD_CC_CE];
	wire wt_q   = cache_q[ASD_CC_WT];
	wire cb_q   = cache_q[ASD_CC_CB];
	wire ora_q  = cache_q[ASD_CC_ORA];

	// Read mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	assign rd_mux = sel_xlat  ? {29'h0, xlat_q}  :
	                sel_cache ? {28'h0, cache_q} :
	                sel_ptag  ? {24'h0, ptag_q}  :
	                sel_fault ? fault_q          : 32'h0000_0000;

	// Writes; reserved bits are dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			xlat_q  <= ASD_XLAT_RST;
			cache_q <= ASD_CACHE_RST;
			ptag_q  <= ASD_PTAG_RST;
		end else if (reg_wr) begin
			if (sel_xlat)
				xlat_q <= reg_wdata[2:0];
			if (sel_cache)
				cache_q <= reg_wdata[3:0];
			if (sel_ptag)
				ptag_q <= reg_wdata[7:0]; // Process switch, no purge
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////
	// Address classification

	asd_region_t region;
	logic        is_sq;
	logic        is_arr;
	logic        is_creg;
	logic        is_p4rsvd;
	logic        is_oram;
	logic [2:0]  raw_area;

	asd_region_classify u_classify (
		.addr      (req_addr),
		.region    (region),
		.is_sq     (is_sq),
		.is_arr    (is_arr),
		.is_creg   (is_creg),
		.is_p4rsvd (is_p4rsvd),
		.is_oram   (is_oram),
		.area      (raw_area)
	);

	wire rg_low  = (region == ASD_RG_LOW);
	wire rg_cdir = (region == ASD_RG_CDIR);
	wire rg_udir = (region == ASD_RG_UDIR);
	wire rg_high = (region == ASD_RG_HIGH);
	wire rg_ctrl = (region == ASD_RG_CTRL);

	////////////////////////////////////////////////////////////////////
	// Protection and translation decisions

	// Upper half is privileged only, store queue aside
	wire user_upper = ~req_priv & req_addr[31] & ~is_sq;
	// Store queue user lock, untranslated only
	wire sq_locked  = ~req_priv & is_sq & ~at_q & sqlk_q;
	wire aerr       = req_valid & (user_upper | sq_locked);

	// On-chip RAM bypasses translation
	wire oram_hit = ora_q & is_oram;

	// Only low, high and store queue may be translated
	wire xlat = at_q & (rg_low | rg_high | is_sq) & ~oram_hit;

	// Address errors win; TLB is not consulted for them
	assign tlb_lookup   = req_valid & xlat & ~aerr;
	assign tlb_use_instruction_translation_buffer = req_fetch; // Fetch vs data buffer
	assign tlb_tag      = ptag_q;    // Process tag qualifier
	assign tlb_single_virtual = xlat_q[ASD_XL_SV]; // Compare mode

	// Miss only when translation is on
	wire tmiss = tlb_lookup & ~tlb_hit;

	// Physical address: TLB or fold
	wire [28:0] phys = xlat ? tlb_paddr : req_addr[28:0];
	wire [2:0]  area = phys[28:26];
	wire area_rsvd   = (area == ASD_AREA_RSVD);
	wire to_tcreg    = (phys[28:24] == ASD_TCREG_TAG);

	// Target selection
	asd_target_t target;
	always_comb begin
		target = ASD_TG_RSVD;
		if (oram_hit) begin
			// Data only; a fetch there is reserved
			target = req_fetch ? ASD_TG_RSVD : ASD_TG_ORAM;
		end else if (xlat) begin
			if (is_sq)
				target = ASD_TG_SQ;
			else if (to_tcreg)
				target = ASD_TG_CREG; // Area 7 top via TLB
			else if (area_rsvd)
				target = ASD_TG_RSVD;
			else
				target = ASD_TG_EXT;
		end else if (rg_ctrl) begin
			if (is_sq)
				target = ASD_TG_SQ;
			else if (is_arr)
				target = ASD_TG_ARR;
			else if (is_creg)
				target = ASD_TG_CREG;
			else if (is_p4rsvd)
				target = ASD_TG_RSVD; // Gaps of the control region
		end else if (area_rsvd) begin
			target = ASD_TG_RSVD;     // Folded area 7
		end else begin
			target = ASD_TG_EXT;
		end
	end

	// Cacheability: only external memory, never uncached-direct
	// Control pages stay uncached as their target is not external memory
	wire page_c  = xlat ? tlb_cacheable : 1'b1;
	wire cached  = ce_q & page_c & ~rg_udir & ~rg_ctrl
	               & (target == ASD_TG_EXT);
	// Copy-back select only for cached-direct; page bit if translated
	wire wthru   = xlat    ? tlb_write_through :
	               rg_cdir ? ~cb_q : wt_q;

	////////////////////////////////////////////////////////////////////
	// Registered result

	logic        vld_q;
	logic        aerr_q;
	logic        miss_q;
	asd_target_t tgt_q;
	logic [28:0] pa_q;
	logic [2:0]  area_q;
	logic [2:0]  asel_q;
	logic        c_q;
	logic        wt_rsp_q;
	logic        tr_q;

	// One result per request, one cycle later
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vld_q    <= 1'b0;
			aerr_q   <= 1'b0;
			miss_q   <= 1'b0;
			tgt_q    <= ASD_TG_RSVD;
			pa_q     <= 29'h0;
			area_q   <= 3'h0;
			asel_q   <= 3'h0;
			c_q      <= 1'b0;
			wt_rsp_q <= 1'b0;
			tr_q     <= 1'b0;
		end else begin
			vld_q    <= req_valid;
			aerr_q   <= aerr;
			miss_q   <= tmiss;
			tgt_q    <= target;
			pa_q     <= phys;
			area_q   <= area;
			asel_q   <= req_addr[26:24];
			c_q      <= req_valid & ~aerr & ~tmiss & cached;
			wt_rsp_q <= wthru;
			tr_q     <= req_valid & xlat;
		end
	end

	assign rsp_valid         = vld_q;
	assign rsp_addr_error    = aerr_q;
	assign rsp_tlb_miss      = miss_q;
	assign rsp_target        = tgt_q;
	assign rsp_phys_addr     = pa_q;
	assign rsp_area          = area_q;
	assign rsp_array_sel     = asel_q;
	assign rsp_cacheable     = c_q;
	assign rsp_write_through = wt_rsp_q;
	assign rsp_translated    = tr_q;

	// Fault address: only state a fault changes
	wire fault_ev = aerr | tmiss;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			fault_q <= ASD_FAULT_RST;
		else if (fault_ev)
			fault_q <= req_addr;
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_user_upper;
		req_valid && !req_priv && req_addr[31] && !is_sq;
	endsequence

	sequence s_err_seen;
		rsp_addr_error && !rsp_cacheable;
	endsequence

	property p_user_upper;
		@(posedge core_clk) disable iff (!nrst)
		s_user_upper |=> s_err_seen;
	endproperty
	a_user_upper: assert property (p_user_upper)
		else $error("user upper access not refused");

	property p_user_low_ok;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && !req_priv && !req_addr[31]) |=> !rsp_addr_error;
	endproperty
	a_user_low_ok: assert property (p_user_low_ok)
		else $error("user low access refused");

	property p_fold;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && !at_q) |=>
		(rsp_phys_addr == $past(req_addr[28:0])) && !rsp_tlb_miss;
	endproperty
	a_fold: assert property (p_fold)
		else $error("untranslated fold or miss wrong");

	property p_udir_uncached;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && req_addr[31:29] == 3'h5) |=>
		!rsp_cacheable && !rsp_translated;
	endproperty
	a_udir_uncached: assert property (p_udir_uncached)
		else $error("uncached-direct region cached or translated");

	property p_array_win;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && req_priv && req_addr[31:27] == 5'h1e) |=>
		rsp_target == ASD_TG_ARR && !rsp_cacheable &&
		rsp_array_sel == $past(req_addr[26:24]);
	endproperty
	a_array_win: assert property (p_array_win)
		else $error("array window decode wrong");

	property p_creg;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && req_priv && req_addr[31:24] == 8'hff) |=>
		rsp_target == ASD_TG_CREG;
	endproperty
	a_creg: assert property (p_creg)
		else $error("control register area not decoded");

	property p_sq_lock;
		@(posedge core_clk) disable iff (!nrst)
		(req_valid && !req_priv && is_sq && !at_q) |=>
		rsp_addr_error == $past(sqlk_q);
	endproperty
	a_sq_lock: assert property (p_sq_lock)
		else $error("store queue lock wrong");

	property p_miss;
		@(posedge core_clk) disable iff (!nrst)
		(tlb_lookup && !tlb_hit) |=> rsp_tlb_miss && rsp_translated
		&& !rsp_cacheable;
	endproperty
	a_miss: assert property (p_miss)
		else $error("TLB miss not reported once");

	property p_area;
		@(posedge core_clk) disable iff (!nrst)
		rsp_valid |-> rsp_area == rsp_phys_addr[28:26] &&
		(rsp_area != 3'h7 || rsp_target != ASD_TG_EXT);
	endproperty
	a_area: assert property (p_area)
		else $error("area field or area 7 wrong");

	property p_fault_hold;
		@(posedge core_clk) disable iff (!nrst)
		!fault_ev |=> $stable(fault_q);
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault address changed without fault");

endmodule : asd_decoder

`default_nettype wire

// File: asd_tlb_model.sv
// Purpose: Behavioural translation buffer facing the decoder's lookup port.
// Assumes: Answers in the lookup cycle, as the decoder samples it there.
// Notes:   Mapping is a fixed scramble of the virtual address.
`default_nettype none

module asd_tlb_model (
	// Lookup request
	input  wire logic        tlb_lookup,
	input  wire logic        tlb_use_instruction_translation_buffer,
	input  wire logic [7:0]  tlb_tag,
	input  wire logic [31:0] vaddr,
	input  wire logic        miss_force,
	// Answer
	output logic             tlb_hit,
	output logic [28:0]      tlb_paddr,
	output logic             tlb_cacheable,
	output logic             tlb_write_through
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////
	logic [28:0] map_w;
	logic        card_w;

	// Tag and buffer choice both move the page, so a wrong one shows
	assign map_w  = vaddr[28:0] ^ {tlb_tag, 21'h0} ^ {20'h0, tlb_use_instruction_translation_buffer, 8'h0};
	assign card_w = (map_w[28:26] == 3'h5) | (map_w[28:26] == 3'h6);
	// Outside a lookup the answer lines carry junk, never the last value
	assign tlb_hit   = tlb_lookup ? ~miss_force : vaddr[4];
	assign tlb_paddr = tlb_lookup ? map_w : ~vaddr[28:0];
	// Pages onto control registers are never cacheable
	assign tlb_cacheable = tlb_lookup ?
		(vaddr[12] & (map_w[28:24] != 5'h1f)) : vaddr[3];
	// Card areas never copy-back
	assign tlb_write_through = tlb_lookup ? (vaddr[13] | card_w) : ~vaddr[3];
endmodule // asd_tlb_model

`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the address space decoder.
// Assumes: Decoder answers one cycle after each request.
// Notes:   Random region-biased traffic against a reference model.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import asd_pkg::*;

	typedef struct packed {
		logic        err;
		logic        miss;
		logic        lk;
		logic        tr;
		logic        cach;
		logic        wt;
		asd_target_t tg;
		logic [28:0] pa;
		logic [31:0] a;
	} asd_exp_t;

	////////////////////////////////////////////////////////////////////////
	logic        core_clk, nrst, reg_wr, reg_rd, req_valid, req_priv;
	logic        req_fetch, miss_force, tlb_lookup, tlb_use_instruction_translation_buffer, tlb_sv;
	logic        tlb_hit, tlb_c, tlb_wt, rsp_valid, rsp_addr_error;
	logic        rsp_tlb_miss, rsp_cacheable, rsp_write_through;
	logic        rsp_translated;
	logic [7:0]  reg_addr, tlb_tag_w, tg;
	logic [31:0] reg_wdata, reg_rdata, req_addr, last_fault, r;
	logic [28:0] tlb_paddr, rsp_phys_addr;
	logic [2:0]  rsp_area, rsp_array_sel, xl;
	logic [3:0]  cc;
	asd_target_t rsp_target;
	asd_exp_t    q[$];
	asd_exp_t    e;
	integer      seed, err_total, compares, cyc;
	localparam logic [7:0] TOPS [16] = '{8'h00, 8'h1c, 8'h1f, 8'h7c, 8'h7f,
		8'h80, 8'h9c, 8'h9f, 8'ha0, 8'hbf, 8'hc0, 8'he0, 8'he4, 8'hf0,
		8'hf8, 8'hff};
	localparam logic [31:0] OFS [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10};
	localparam logic [31:0] MSK [5] = '{32'h7, 32'hf, 32'hff, 32'h0, 32'h0};

	asd_decoder DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req_addr(req_addr),
		.req_priv(req_priv), .req_fetch(req_fetch), .tlb_lookup(tlb_lookup),
		.tlb_use_instruction_translation_buffer(tlb_use_instruction_translation_buffer), .tlb_tag(tlb_tag_w),
		.tlb_single_virtual(tlb_sv), .tlb_hit(tlb_hit),
		.tlb_paddr(tlb_paddr), .tlb_cacheable(tlb_c),
		.tlb_write_through(tlb_wt), .rsp_valid(rsp_valid),
		.rsp_addr_error(rsp_addr_error), .rsp_tlb_miss(rsp_tlb_miss),
		.rsp_target(rsp_target), .rsp_phys_addr(rsp_phys_addr),
		.rsp_area(rsp_area), .rsp_array_sel(rsp_array_sel),
		.rsp_cacheable(rsp_cacheable), .rsp_write_through(rsp_write_through),
		.rsp_translated(rsp_translated));

	asd_tlb_model tlb (.tlb_lookup(tlb_lookup), .tlb_use_instruction_translation_buffer(tlb_use_instruction_translation_buffer),
		.tlb_tag(tlb_tag_w), .vaddr(req_addr), .miss_force(miss_force),
		.tlb_hit(tlb_hit), .tlb_paddr(tlb_paddr), .tlb_cacheable(tlb_c),
		.tlb_write_through(tlb_wt));

	////////////////////////////////////////////////////////////////////////
	// Clock, cycle ceiling well above the planned run
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total = err_total + 1;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Register port; bench copy of the fields follows each write
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == ASD_OFS_XLAT) xl = d[2:0];
		if (a == ASD_OFS_CACHE) cc = d[3:0];
		if (a == ASD_OFS_PTAG) tg = d[7:0];
	endtask

	// Data stands in the cycle after the strobe, zero in the next
	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
		@(negedge core_clk);
		chk(reg_rdata, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reference decode of one request under the bench's register copy
	function automatic asd_exp_t calc(input logic [31:0] a, input logic pv,
		input logic fe, input logic fm);
		asd_exp_t    x;
		logic        sq, operand_ram_select, ctl;
		logic [28:0] m;
		sq = a[31:26] == 6'h38;
		ctl = a[31:29] == 3'h7;
		operand_ram_select = cc[3] && a[31:26] == 6'h1f;
		m = a[28:0] ^ {tg, 21'h0} ^ {20'h0, fe, 8'h0};
		x = '0;
		x.a = a;
		x.err = !pv && ((a[31] && !sq) || (sq && !xl[0] && xl[1]));
		x.tr = xl[0] && (!a[31] || a[31:29] == 3'h6 || sq) && !operand_ram_select;
		x.lk = x.tr && !x.err;
		x.miss = x.lk && fm;
		x.pa = x.tr ? m : a[28:0];
		if (operand_ram_select) x.tg = fe ? ASD_TG_RSVD : ASD_TG_ORAM;
		else if (sq) x.tg = ASD_TG_SQ;
		else if (a[31:27] == 5'h1e) x.tg = ASD_TG_ARR;
		else if (a[31:24] == 8'hff) x.tg = ASD_TG_CREG;
		else if (ctl) x.tg = ASD_TG_RSVD;
		else if (x.pa[28:26] != 3'h7) x.tg = ASD_TG_EXT;
		else if (x.tr && x.pa[28:24] == 5'h1f) x.tg = ASD_TG_CREG;
		else x.tg = ASD_TG_RSVD;
		x.cach = cc[0] && !x.err && !x.miss && x.tg == ASD_TG_EXT &&
			a[31:29] != 3'h5 && !ctl && (x.tr ? a[12] : 1'b1);
		x.wt = x.tr ? (a[13] | m[28:26] == 3'h5 | m[28:26] == 3'h6) :
			(a[31:29] == 3'h4 ? !cc[2] : cc[1]);
		return x;
	endfunction

	// Checks each answer one cycle after its request
	always @(negedge core_clk) begin
		if (nrst) begin
			chk(32'(rsp_valid), 32'(q.size() != 0));
			if (q.size() != 0) begin
				e = q.pop_front();
				chk(32'(rsp_addr_error), 32'(e.err));
				chk(32'(rsp_tlb_miss), 32'(e.miss));
				chk(32'(rsp_cacheable), 32'(e.cach));
				if (e.cach) chk(32'(rsp_write_through), 32'(e.wt));
				if (!e.err) chk(32'(rsp_translated), 32'(e.tr));
				if (!e.err && !e.miss) begin
					chk(32'(rsp_target), 32'(e.tg));
					if (e.tg == ASD_TG_EXT) chk(32'(rsp_phys_addr), 32'(e.pa));
					if (e.tg == ASD_TG_EXT) chk(32'(rsp_area), 32'(e.pa[28:26]));
					if (e.tg == ASD_TG_ARR) chk(32'(rsp_array_sel), 32'(e.a[26:24]));
				end
			end
			if (req_valid) begin
				e = calc(req_addr, req_priv, req_fetch, miss_force);
				chk(32'(tlb_lookup), 32'(e.lk));
				if (e.lk) chk(32'(tlb_use_instruction_translation_buffer), 32'(req_fetch));
				chk(32'(tlb_tag_w), 32'(tg));
				chk(32'(tlb_sv), 32'(xl[2]));
				if (e.err || e.miss) last_fault = req_addr;
				q.push_back(e);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		{reg_wr, reg_rd, req_valid, req_priv, req_fetch, miss_force} = '0;
		{reg_addr, reg_wdata, req_addr} = '0;
		{xl, cc, tg, last_fault} = '0;
		{err_total, compares, cyc} = '0;
		seed = 76488;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		// Reset values, then reserved bits, read-only and unmapped places
		for (int i = 0; i < 5; i++) reg_read(OFS[i][7:0], 32'h0);
		for (int i = 0; i < 5; i++) reg_write(OFS[i][7:0], 32'hffff_ffff);
		for (int i = 0; i < 5; i++) reg_read(OFS[i][7:0], MSK[i]);
		$display("register test done");
		// Random settings, then a back-to-back burst over all windows
		for (int n = 0; n < 40; n++) begin
			reg_write(ASD_OFS_XLAT, $random(seed));
			reg_write(ASD_OFS_CACHE, $random(seed));
			reg_write(ASD_OFS_PTAG, $random(seed));
			for (int k = 0; k < 24; k++) begin
				@(posedge core_clk);
				r = $random(seed);
				req_valid <= 1'b1;
				req_addr[23:0] <= 24'($random(seed));
				req_addr[31:24] <= (r[3:0] == 4'h0) ? r[31:24] :
					(r[3:0] == 4'hd) ? {5'h1e, r[10:8]} : TOPS[r[3:0]];
				req_priv <= r[4];
				req_fetch <= r[5];
				miss_force <= r[6] & r[7];
			end
			@(posedge core_clk);
			req_valid <= 1'b0;
			@(posedge core_clk);
			reg_read(ASD_OFS_FAULT, last_fault);
		end
		$display("access test done");
		close_out();
	end
endmodule // testbench

`default_nettype wire
